/* File: design/tcp_pkg.sv */
// Register map, field positions and constants of the compare/pulse/PWM timer
package tcp_pkg;
  // Byte addresses, one register per aligned word
  localparam logic [5:0] ADR_CR1 = 6'h00;
  localparam logic [5:0] ADR_CR2 = 6'h04;
  localparam logic [5:0] ADR_SR = 6'h08;
  localparam logic [5:0] ADR_OC1H = 6'h0C;
  localparam logic [5:0] ADR_OC1L = 6'h10;
  localparam logic [5:0] ADR_OC2H = 6'h14;
  localparam logic [5:0] ADR_OC2L = 6'h18;
  localparam logic [5:0] ADR_CNTH = 6'h1C;
  localparam logic [5:0] ADR_CNTL = 6'h20;
  localparam logic [5:0] ADR_IC1H = 6'h24;
  localparam logic [5:0] ADR_IC1L = 6'h28;
  localparam logic [5:0] ADR_IC2H = 6'h2C;
  localparam logic [5:0] ADR_IC2L = 6'h30;
  // timer_control_one fields
  localparam int B_CAPTURE_IRQ_ENABLE = 7;
  localparam int B_COMPARE_IRQ_ENABLE = 6;
  localparam int B_TOIE = 5;
  localparam int B_FOLV2 = 4;
  localparam int B_FOLV1 = 3;
  localparam int B_LVL2 = 2;
  localparam int B_CAPTURE_EDGE_SELECT_ONE = 1;
  localparam int B_LVL1 = 0;
  // timer_control_two fields
  localparam int B_COMPARE_PIN_ENABLE_ONE = 7;
  localparam int B_OC2E = 6;
  localparam int B_OPM = 5;
  localparam int B_PWM = 4;
  localparam int B_CCH = 3;
  localparam int B_CCL = 2;
  localparam int B_IEDG2 = 1;
  localparam int B_EXEDG = 0;
  // Flag vector index; status bit is index plus FLAG_LSB
  localparam int F_COMPARE_FLAG_TWO = 0;
  localparam int F_CAPTURE_FLAG_TWO = 1;
  localparam int F_TOF = 2;
  localparam int F_COMPARE_FLAG_ONE = 3;
  localparam int F_CAPTURE_FLAG_ONE = 4;
  localparam int NFLAG = 5;
  localparam int FLAG_LSB = 3;
  // Clock select codes
  localparam logic [1:0] CLK_DIV2 = 2'h0;
  localparam logic [1:0] CLK_DIV4 = 2'h1;
  localparam logic [1:0] CLK_EXT = 2'h3;
  // Values
  localparam logic [15:0] CNT_RESET = 16'hFFFC;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CAP_OPM = 16'hFFFD;
  localparam logic [15:0] OC_RESET = 16'h8000;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [7:0] CR_RESET = 8'h00;
  typedef enum logic [1:0] {TCP_NORMAL, TCP_ONE_PULSE, TCP_PWM} tcp_mode_t;
endpackage : tcp_pkg

/* File: design/tcp_timer.sv */
// Output-compare timer with one-pulse and PWM modes, Avalon-MM slave
`timescale 1ns/100ps
// Summary of operation
// - Counter equal to compare value sets its flag and drives its level on enabled pin.
// - Compare pin latches are low during reset.
// - Compare match interrupts only with compare enable set and processor mask clear.
// - Compare flag clears after status read seeing it, then low-byte access.
// - High-byte write suspends compare; low-byte write resumes and clears flag.
// - Match at value for CPU/2, at value plus one for slower clocks.
// - Disabled pin stays general I/O; flag and interrupt still work.
// - Force bit with pin enabled copies level, no flag, no interrupt.
// - Force bits ignored in one-pulse and PWM modes.
// - One-pulse select uses capture one as trigger, compare one for length.
// - One-pulse trigger reloads FFFC, drives level two, sets capture flag, captures FFFD.
// - One-pulse compare one match drives level one, ending pulse.
// - One-pulse never sets compare flag one; compare flag two still works.
// - One-pulse compare two flags time but drives no waveform.
// - Both mode bits set means PWM only.
// - One-pulse: capture pin one never captures; capture two still captures.
// - PWM disconnects capture pin one; capture two stays usable.
// - PWM: compare one match drives level one, compare two drives level two.
// - PWM compare two match reloads counter to FFFC.
// - PWM never sets compare flags.
// - PWM compare two match sets capture flag one, may interrupt.
// - Compare values reset to 8000 and hardware never changes them.
// - Counter resets to FFFC, the only value ever reloaded.
// - Clock select both ones picks external clock, else divided CPU clock.
module tcp_timer
  import tcp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Timer pins
  input wire logic capture_pin_one,
  input wire logic capture_pin_two,
  input wire logic ext_clock_pin,
  input wire logic cpu_irq_mask,
  output logic compare_output_pin_one,
  output logic compare_output_pin_one_oe,
  output logic compare_output_pin_two,
  output logic compare_output_pin_two_oe,
  output logic timer_irq
);

  // ************************************************
  // State
  // ************************************************
  logic [7:0] timer_control_one;
  logic [7:0] timer_control_two;
  logic [15:0] compare_value_one;
  logic [15:0] compare_value_two;
  logic [15:0] capture_value_one;
  logic [15:0] capture_value_two;
  logic [15:0] cnt;
  logic [2:0] presc;
  logic cnt_new;
  logic ext_prev;
  logic cap1_prev;
  logic cap2_prev;
  logic inhibit_one;
  logic inhibit_two;
  logic [NFLAG-1:0] flags;
  logic [NFLAG-1:0] armed;

  // ************************************************
  // Bus decode
  // ************************************************
  // One wait state per request; the access lands when waitrequest is low
  wire acc = (avs_read | avs_write) & ~avs_waitrequest;
  wire wr = acc & avs_write & avs_byteenable[0];
  wire rd = acc & avs_read;
  wire [7:0] wd = avs_writedata[7:0];
  wire h_cr1 = avs_address == ADR_CR1;
  wire h_cr2 = avs_address == ADR_CR2;
  wire h_sr = avs_address == ADR_SR;
  wire h_oc1h = avs_address == ADR_OC1H;
  wire h_oc1l = avs_address == ADR_OC1L;
  wire h_oc2h = avs_address == ADR_OC2H;
  wire h_oc2l = avs_address == ADR_OC2L;
  wire h_cnth = avs_address == ADR_CNTH;
  wire h_cntl = avs_address == ADR_CNTL;
  wire h_ic1h = avs_address == ADR_IC1H;
  wire h_ic1l = avs_address == ADR_IC1L;
  wire h_ic2h = avs_address == ADR_IC2H;
  wire h_ic2l = avs_address == ADR_IC2L;
  wire [7:0] status = {flags, 3'h0};
  wire [7:0] rd_mux =
    h_cr1 ? timer_control_one :
    h_cr2 ? timer_control_two :
    h_sr ? status :
    h_oc1h ? compare_value_one[15:8] :
    h_oc1l ? compare_value_one[7:0] :
    h_oc2h ? compare_value_two[15:8] :
    h_oc2l ? compare_value_two[7:0] :
    h_cnth ? cnt[15:8] :
    h_cntl ? cnt[7:0] :
    h_ic1h ? capture_value_one[15:8] :
    h_ic1l ? capture_value_one[7:0] :
    h_ic2h ? capture_value_two[15:8] :
    h_ic2l ? capture_value_two[7:0] :
    8'h00;

  // ************************************************
  // Mode and clock selection
  // ************************************************
  wire opm_bit = timer_control_two[B_OPM];
  wire pwm_bit = timer_control_two[B_PWM];
  tcp_mode_t mode;
  assign mode = pwm_bit ? TCP_PWM : opm_bit ? TCP_ONE_PULSE : TCP_NORMAL;
  wire normal = mode == TCP_NORMAL;
  wire [1:0] clk_sel = timer_control_two[B_CCH:B_CCL];
  wire ext_edge = timer_control_two[B_EXEDG] ?
    (ext_clock_pin & ~ext_prev) :
    (~ext_clock_pin & ext_prev);
  wire tick_int = (clk_sel == CLK_DIV2) ? presc[0] :
    (clk_sel == CLK_DIV4) ? &presc[1:0] :
    &presc;
  wire tick = (clk_sel == CLK_EXT) ? ext_edge : tick_int;
  wire fast = clk_sel == CLK_DIV2;

  // ************************************************
  // Capture edges and compare matches
  // ************************************************
  wire cap1_edge = timer_control_one[B_CAPTURE_EDGE_SELECT_ONE] ?
    (capture_pin_one & ~cap1_prev) :
    (~capture_pin_one & cap1_prev);
  wire cap2_edge = timer_control_two[B_IEDG2] ?
    (capture_pin_two & ~cap2_prev) :
    (~capture_pin_two & cap2_prev);
  // In one-pulse mode capture pin one is only a trigger; in PWM mode it is ignored
  wire cap1_norm = cap1_edge & normal;
  wire opm_trig = cap1_edge & (mode == TCP_ONE_PULSE);
  wire [15:0] tgt1 = fast ? compare_value_one : 16'(compare_value_one + ONE16);
  wire [15:0] tgt2 = fast ? compare_value_two : 16'(compare_value_two + ONE16);
  wire m1 = cnt_new & ~inhibit_one & (cnt == tgt1);
  wire m2 = cnt_new & ~inhibit_two & (cnt == tgt2);
  wire pwm_per = m2 & (mode == TCP_PWM);
  wire cnt_wr = wr & h_cntl;
  wire reload = cnt_wr | opm_trig | pwm_per;
  wire overflow = tick & (cnt == CNT_MAX) & ~reload;
  wire [15:0] next_cnt = reload ? CNT_RESET :
    tick ? 16'(cnt + ONE16) :
    cnt;
  wire compare_pin_enable_one = timer_control_two[B_COMPARE_PIN_ENABLE_ONE];
  wire oc2e = timer_control_two[B_OC2E];
  wire lvl1 = timer_control_one[B_LVL1];
  wire lvl2 = timer_control_one[B_LVL2];
  wire force1 = normal & timer_control_one[B_FOLV1];
  wire force2 = normal & timer_control_one[B_FOLV2];

  // Pin one: trigger or PWM compare two match wins over compare one match and force within a cycle
  wire p1_to2 = opm_trig | (m2 & (mode == TCP_PWM));
  wire p1_to1 = m1 | force1;
  wire p1_upd = compare_pin_enable_one & (p1_to2 | p1_to1);
  wire next_pin1 = p1_to2 ? lvl2 : lvl1;
  wire p2_upd = oc2e & normal & (m2 | force2);

  // ************************************************
  // Flags
  // ************************************************
  wire [NFLAG-1:0] set_v;
  wire [NFLAG-1:0] low_acc;
  wire [NFLAG-1:0] extra_clr;
  assign set_v[F_COMPARE_FLAG_ONE] = m1 & normal;
  assign set_v[F_COMPARE_FLAG_TWO] = m2 & (mode != TCP_PWM);
  assign set_v[F_CAPTURE_FLAG_ONE] = cap1_norm | opm_trig | pwm_per;
  assign set_v[F_CAPTURE_FLAG_TWO] = cap2_edge;
  assign set_v[F_TOF] = overflow;
  assign low_acc[F_COMPARE_FLAG_ONE] = acc & h_oc1l;
  assign low_acc[F_COMPARE_FLAG_TWO] = acc & h_oc2l;
  assign low_acc[F_CAPTURE_FLAG_ONE] = acc & h_ic1l;
  assign low_acc[F_CAPTURE_FLAG_TWO] = acc & h_ic2l;
  assign low_acc[F_TOF] = acc & h_cntl;
  assign extra_clr = {1'b0, wr & h_oc1l, 2'h0, wr & h_oc2l};
  wire [NFLAG-1:0] clr_v = (armed & low_acc) | extra_clr;
  wire sr_rd = rd & h_sr;

  // Set wins over clear in one cycle
  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi++) begin : g_flag
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          flags[gi] <= 1'b0;
          armed[gi] <= 1'b0;
        end else begin
          flags[gi] <= set_v[gi] | (flags[gi] & ~clr_v[gi]);
          armed[gi] <= (sr_rd & flags[gi]) | (armed[gi] & ~low_acc[gi]);
        end
      end
    end
  endgenerate

  wire next_irq = ~cpu_irq_mask & ((timer_control_one[B_CAPTURE_IRQ_ENABLE] & (flags[F_CAPTURE_FLAG_ONE] | flags[F_CAPTURE_FLAG_TWO])) |
    (timer_control_one[B_COMPARE_IRQ_ENABLE] & (flags[F_COMPARE_FLAG_ONE] | flags[F_COMPARE_FLAG_TWO])) |
    (timer_control_one[B_TOIE] & flags[F_TOF]));

  // ************************************************
  // Registers
  // ************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      timer_irq <= 1'b0;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      avs_readdata <= {24'h00_0000, rd_mux};
      timer_irq <= next_irq;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_one <= CR_RESET;
      timer_control_two <= CR_RESET;
    end else begin
      if (wr & h_cr1) timer_control_one <= wd;
      if (wr & h_cr2) timer_control_two <= wd;
    end
  end

  // Only software writes reach the compare values
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_value_one <= OC_RESET;
      compare_value_two <= OC_RESET;
      inhibit_one <= 1'b0;
      inhibit_two <= 1'b0;
    end else begin
      if (wr & h_oc1h) compare_value_one[15:8] <= wd;
      if (wr & h_oc1l) compare_value_one[7:0] <= wd;
      if (wr & h_oc2h) compare_value_two[15:8] <= wd;
      if (wr & h_oc2l) compare_value_two[7:0] <= wd;
      inhibit_one <= (wr & h_oc1h) | (inhibit_one & ~(wr & h_oc1l));
      inhibit_two <= (wr & h_oc2h) | (inhibit_two & ~(wr & h_oc2l));
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= CNT_RESET;
      presc <= 3'h0;
      cnt_new <= 1'b0;
      ext_prev <= 1'b0;
      cap1_prev <= 1'b0;
      cap2_prev <= 1'b0;
    end else begin
      cnt <= next_cnt;
      presc <= 3'(presc + 3'h1);
      cnt_new <= tick | reload;
      ext_prev <= ext_clock_pin;
      cap1_prev <= capture_pin_one;
      cap2_prev <= capture_pin_two;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_value_one <= 16'h0000;
      capture_value_two <= 16'h0000;
    end else begin
      if (opm_trig) capture_value_one <= CAP_OPM;
      else if (cap1_norm) capture_value_one <= cnt;
      if (cap2_edge) capture_value_two <= cnt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_output_pin_one <= 1'b0;
      compare_output_pin_two <= 1'b0;
      compare_output_pin_one_oe <= 1'b0;
      compare_output_pin_two_oe <= 1'b0;
    end else begin
      if (p1_upd) compare_output_pin_one <= next_pin1;
      if (p2_upd) compare_output_pin_two <= lvl2;
      compare_output_pin_one_oe <= compare_pin_enable_one;
      compare_output_pin_two_oe <= oc2e;
    end
  end

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_opm_fire;
    opm_trig && compare_pin_enable_one;
  endsequence
  sequence s_opm_done;
    cnt == CNT_RESET && capture_value_one == CAP_OPM && flags[F_CAPTURE_FLAG_ONE];
  endsequence
  sequence s_pwm_end;
    pwm_per && compare_pin_enable_one;
  endsequence
  sequence s_pwm_low;
    compare_output_pin_one == $past(lvl2) && cnt == CNT_RESET;
  endsequence

  a_cmp_flag_set: assert property (m1 && normal |=> flags[F_COMPARE_FLAG_ONE])
    else $error("compare one match did not set its flag");
  a_cmp_pin_level: assert property (m1 && compare_pin_enable_one && !p1_to2 |=> compare_output_pin_one == $past(lvl1))
    else $error("pin one did not take level one on match");
  a_irq_gated_mask: assert property (cpu_irq_mask |=> !timer_irq)
    else $error("interrupt raised while processor mask set");
  a_flag_clear_cause: assert property ($fell(flags[F_COMPARE_FLAG_ONE]) |-> $past(clr_v[F_COMPARE_FLAG_ONE]))
    else $error("compare flag one cleared without cause");
  a_inhibit_no_match: assert property (wr && h_oc1h |=> !m1 until (wr && h_oc1l))
    else $error("compare one matched while suspended");
  a_opm_no_compare_flag_one: assert property ($rose(flags[F_COMPARE_FLAG_ONE]) |-> $past(mode) == TCP_NORMAL)
    else $error("compare flag one set outside normal mode");
  a_opm_trigger: assert property (s_opm_fire |=> s_opm_done and compare_output_pin_one == $past(lvl2))
    else $error("one-pulse trigger effects missing");
  a_pwm_period: assert property (pwm_per |=> cnt == CNT_RESET && flags[F_CAPTURE_FLAG_ONE] && !$rose(flags[F_COMPARE_FLAG_TWO]))
    else $error("PWM period reload wrong");
  a_force_level: assert property (force1 && compare_pin_enable_one && !m1 |=> compare_output_pin_one == $past(lvl1) && !$rose(flags[F_COMPARE_FLAG_ONE]))
    else $error("forced level not applied");
  a_cnt_reload_val: assert property (reload |=> cnt == CNT_RESET)
    else $error("counter reloaded with wrong value");

  // Compare path, counter clock and overflow
  a_force_two: assert property (force2 && oc2e |=> compare_output_pin_two == $past(lvl2))
    else $error("forced level two not applied");
  a_pin_disabled: assert property (!compare_pin_enable_one |=> $stable(compare_output_pin_one))
    else $error("disabled pin one changed");
  a_fast_match: assert property (m1 && fast |-> cnt == compare_value_one)
    else $error("fast clock match at wrong count");
  a_slow_match: assert property (m1 && !fast |-> 16'(cnt - ONE16) == compare_value_one)
    else $error("slow clock match at wrong count");
  a_ext_tick: assert property (clk_sel == CLK_EXT && !ext_edge && !reload |=> $stable(cnt))
    else $error("counter moved without external edge");
  a_cmp_values_hold: assert property (!wr |=> $stable(compare_value_one) && $stable(compare_value_two))
    else $error("compare value changed without write");
  a_ovf_flag: assert property (overflow |=> flags[F_TOF])
    else $error("overflow did not set its flag");

  // One-pulse and PWM
  a_opm_pulse_end: assert property (m1 && mode == TCP_ONE_PULSE && compare_pin_enable_one && !opm_trig |=> compare_output_pin_one == $past(lvl1))
    else $error("pulse not ended by level one");
  a_opm_compare_flag_two: assert property (m2 && mode == TCP_ONE_PULSE |=> flags[F_COMPARE_FLAG_TWO])
    else $error("compare flag two lost in one-pulse mode");
  a_opm_pin_two: assert property (mode != TCP_NORMAL |=> $stable(compare_output_pin_two))
    else $error("pin two driven outside normal mode");
  a_force_ignored: assert property (!normal && !m1 && !p1_to2 |=> $stable(compare_output_pin_one))
    else $error("pin one moved without event in special mode");
  a_pwm_pin_one: assert property (m1 && mode == TCP_PWM && !m2 && compare_pin_enable_one |=> compare_output_pin_one == $past(lvl1))
    else $error("PWM pin missed level one");
  a_pwm_pin_two: assert property (s_pwm_end |=> s_pwm_low)
    else $error("PWM period end wrong");
  a_pwm_no_flags: assert property (mode == TCP_PWM |=> !$rose(flags[F_COMPARE_FLAG_ONE]) && !$rose(flags[F_COMPARE_FLAG_TWO]))
    else $error("compare flag set in PWM mode");

  // Capture and interrupt
  a_cap_pin_off: assert property (mode != TCP_NORMAL && !opm_trig |=> $stable(capture_value_one))
    else $error("capture one loaded outside normal mode");
  a_cap_two_works: assert property (cap2_edge |=> flags[F_CAPTURE_FLAG_TWO] && capture_value_two == $past(cnt))
    else $error("capture two did not capture");
  a_irq_from_flag: assert property (!cpu_irq_mask && timer_control_one[B_COMPARE_IRQ_ENABLE] && flags[F_COMPARE_FLAG_ONE] |=> timer_irq)
    else $error("compare interrupt missing");
  a_opm_irq: assert property (!cpu_irq_mask && timer_control_one[B_COMPARE_IRQ_ENABLE] && flags[F_COMPARE_FLAG_TWO] |=> timer_irq)
    else $error("compare two interrupt missing");
  a_capture_irq: assert property (!cpu_irq_mask && timer_control_one[B_CAPTURE_IRQ_ENABLE] && flags[F_CAPTURE_FLAG_ONE] |=> timer_irq)
    else $error("capture interrupt missing");

endmodule : tcp_timer

/* File: tb/tcp_partner.sv */
// Far-side model: capture trigger source, external clock and compare pin load
`timescale 1ns/100ps
module tcp_partner (
  // Clock and command from the bench
  input wire logic sys_clk,
  input wire logic fire_one,
  // Compare pin from the timer
  input wire logic compare_output_pin_one,
  input wire logic compare_output_pin_one_oe,
  // Inputs of the timer
  output logic capture_pin_one,
  output logic capture_pin_two,
  output logic ext_clock_pin,
  // Pad level seen by the load
  output logic pad_one
);
  logic [2:0] div = 3'h0;
  // Pull-down holds the pad when the timer lets go
  assign pad_one = compare_output_pin_one_oe ? compare_output_pin_one : 1'b0;
  // Free-running clock, four cycles between edges
  assign ext_clock_pin = div[2];
  assign capture_pin_two = 1'b0;
  initial capture_pin_one = 1'b0;
  always @(posedge sys_clk) begin
    capture_pin_one <= fire_one;
    div <= div + 3'h1;
  end
endmodule : tcp_partner

/* File: tb/testbench.sv */
// Self-checking bench of the compare, one-pulse and PWM timer
`timescale 1ns/100ps
module testbench;
  import tcp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] adr = 6'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic cap1, cap2, ext_clk, pin1, oe1, pin2, oe2, irq, pad1;
  logic mask = 1'b0;
  logic fire = 1'b0;
  logic [31:0] rd;
  int fail_count = 0;
  int num_checks = 0;
  typedef struct {logic [5:0] a; logic [7:0] v;} tcp_row_t;
  tcp_row_t rows [8] = '{'{ADR_SR, 8'h00}, '{ADR_CR1, 8'h00}, '{ADR_CR2, 8'h00}, '{ADR_OC1H, 8'h80},
    '{ADR_OC1L, 8'h00}, '{ADR_OC2H, 8'h80}, '{ADR_OC2L, 8'h00}, '{6'h3C, 8'h00}};

  always #2 sys_clk = ~sys_clk;

  tcp_timer dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
    .avs_byteenable(4'hF), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .capture_pin_one(cap1), .capture_pin_two(cap2), .ext_clock_pin(ext_clk), .cpu_irq_mask(mask),
    .compare_output_pin_one(pin1), .compare_output_pin_one_oe(oe1), .compare_output_pin_two(pin2),
    .compare_output_pin_two_oe(oe2), .timer_irq(irq));
  tcp_partner far (.sys_clk(sys_clk), .fire_one(fire), .compare_output_pin_one(pin1),
    .compare_output_pin_one_oe(oe1), .capture_pin_one(cap1), .capture_pin_two(cap2),
    .ext_clock_pin(ext_clk), .pad_one(pad1));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    adr <= a;
    wr_en <= w;
    rd_en <= !w;
    wdat <= {24'h000000, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    if (wreq !== 1'b0) begin
      fail_count++;
      $display("Error waitrequest expected 0 seen %b", wreq);
      finish_test();
    end
    rd = rdat;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    if (s !== v) begin
      fail_count++;
      $display("Error wait expected %b seen %b", v, s);
      finish_test();
    end
  endtask : wait_lvl

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge sys_clk);
    chk("outputs in reset", 32'h0, {28'h0, pin1, oe1, irq, !wreq});
    rst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (rows[i]) begin
      bus(1'b0, rows[i].a, 8'h00);
      chk("reset value", {24'h0, rows[i].v}, rd);
    end
    $display("Test reset values done");
    bus(1'b1, ADR_CR1, 8'h41);
    bus(1'b1, ADR_OC1H, 8'h00);
    bus(1'b1, ADR_OC1L, 8'h40);
    wait_lvl(irq, 1'b1, 300);
    chk("disabled pin", 32'h0, {30'h0, pin1, oe1});
    mask <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("masked irq", 32'h0, {31'h0, irq});
    mask <= 1'b0;
    bus(1'b0, ADR_OC1L, 8'h00);
    bus(1'b0, ADR_SR, 8'h00);
    chk("flag kept", 32'h40, rd & 32'h48);
    bus(1'b0, ADR_OC1L, 8'h00);
    bus(1'b0, ADR_SR, 8'h00);
    chk("flag cleared", 32'h0, rd & 32'h48);
    $display("Test compare flag done");
    bus(1'b1, ADR_CR1, 8'h01);
    bus(1'b1, ADR_CR2, 8'h80);
    bus(1'b1, ADR_OC1H, 8'h00);
    bus(1'b1, ADR_CNTL, 8'h00);
    repeat (60) @(posedge sys_clk);
    chk("suspended pin", 32'h0, {31'h0, pin1});
    bus(1'b1, ADR_OC1L, 8'h10);
    bus(1'b1, ADR_CNTL, 8'h00);
    wait_lvl(pin1, 1'b1, 100);
    chk("pin enable", 32'h1, {31'h0, oe1});
    bus(1'b1, ADR_CR1, 8'h08);
    wait_lvl(pin1, 1'b0, 10);
    chk("pad level", 32'h0, {31'h0, pad1});
    bus(1'b1, ADR_CR1, 8'h09);
    wait_lvl(pin1, 1'b1, 10);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    chk("pin in reset", 32'h0, {30'h0, pin1, oe1});
    @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    $display("Test compare pin done");
    bus(1'b1, ADR_CR2, 8'hA0);
    bus(1'b1, ADR_CR1, 8'h8B);
    bus(1'b1, ADR_OC1H, 8'h01);
    bus(1'b1, ADR_OC1L, 8'h00);
    repeat (8) @(posedge sys_clk);
    chk("force in pulse mode", 32'h0, {31'h0, pin1});
    fire <= 1'b1;
    wait_lvl(pin1, 1'b1, 700);
    fire <= 1'b0;
    bus(1'b0, ADR_IC1H, 8'h00);
    chk("capture high", 32'hFF, rd);
    bus(1'b0, ADR_IC1L, 8'h00);
    chk("capture low", 32'hFD, rd);
    bus(1'b0, ADR_SR, 8'h00);
    chk("pulse flags", 32'h80, rd & 32'hC8);
    chk("pin two", 32'h0, {30'h0, pin2, oe2});
    chk("capture irq", 32'h1, {31'h0, irq});
    fire <= 1'b1;
    wait_lvl(pin1, 1'b0, 6);
    $display("Test one pulse done");
    bus(1'b0, ADR_IC1L, 8'h00);
    bus(1'b1, ADR_CR2, 8'hB0);
    bus(1'b1, ADR_CR1, 8'h01);
    bus(1'b1, ADR_OC2H, 8'h00);
    bus(1'b1, ADR_OC2L, 8'h30);
    bus(1'b1, ADR_OC1H, 8'h00);
    bus(1'b1, ADR_OC1L, 8'h10);
    wait_lvl(pin1, 1'b1, 200);
    wait_lvl(pin1, 1'b0, 200);
    wait_lvl(pin1, 1'b1, 200);
    bus(1'b0, ADR_SR, 8'h00);
    chk("pwm flags", 32'h80, rd & 32'hC8);
    fire <= 1'b0;
    repeat (4) @(posedge sys_clk);
    bus(1'b0, ADR_IC1L, 8'h00);
    chk("no capture", 32'hFD, rd);
    $display("Test pwm done");
    bus(1'b1, ADR_CR2, 8'h8D);
    bus(1'b1, ADR_CR1, 8'h08);
    bus(1'b1, ADR_CR1, 8'h01);
    bus(1'b1, ADR_OC1H, 8'h00);
    bus(1'b1, ADR_CNTL, 8'h00);
    bus(1'b1, ADR_OC1L, 8'h02);
    wait_lvl(pin1, 1'b1, 200);
    bus(1'b0, ADR_CNTL, 8'h00);
    chk("external match count", 32'h3, rd);
    $display("Test external clock done");
    finish_test();
  end
endmodule : testbench
